// File: rtl/adcseq_top.sv
/*
 converter sequencer: power-up with regulator settle, single and
 free-running conversions, averaging, left-aligned result, input setup.
 assumes the analogue core answers each sample request with a done pulse
 on this clock domain; all registers sit on a plain register port.
*/
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module adcseq_top (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // analogue core
  output logic ldo_enable_o,
  output logic conv_enable_o,
  output logic sample_req_o,
  output logic [adcseq_pkg::CHAN_W-1:0] chan_select_o,
  output logic single_ended_select_o,
  output logic [adcseq_pkg::SCALE_W-1:0] input_scale_select_o,
  output logic input_shift_enable_o,
  output logic [adcseq_pkg::CM_W-1:0] common_mode_adjust_o,
  input wire logic sample_done_i,
  input wire logic [adcseq_pkg::RAW_W-1:0] sample_data_i,
  // status
  output logic conv_done_flag_o
);
  import adcseq_pkg::*;

  typedef struct packed {
    adcseq_state_e st;
    logic power_en;
    logic go_busy;
    logic free_run;
    logic single_end;
    logic done_flag;
    logic [CHAN_W-1:0] chan;
    logic [SCALE_W-1:0] scale;
    logic [AVG_W-1:0] avg_exp;
    logic shift_en;
    logic [CM_W-1:0] cm_adj;
    logic [SETTLE_W-1:0] settle;
    logic [GAP_W-1:0] gap;
    logic [SETTLE_W+1:0] settle_cnt;
    logic [GAP_W-1:0] gap_cnt;
    logic [7:0] smp_cnt;
    logic [ACC_W+7:0] acc;
    logic [RES_W-1:0] result;
    logic [RAW_W-1:0] last_raw;
    logic req;
    logic [15:0] rdata;
  } adcseq_top_s;

  adcseq_top_s s_q;
  adcseq_top_s s_d;
  logic tick;
  logic wr_main;
  logic [7:0] smp_total;
  logic [ACC_W+7:0] acc_next;
  logic [ACC_W+7:0] avg_val;

  adcseq_tick u_tick (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  assign wr_main = reg_wr_i && (reg_addr_i == ADR_CTRL_MAIN);
  assign smp_total = 8'(1 << s_q.avg_exp);
  assign acc_next = s_q.acc + (ACC_W + 8)'(sample_data_i);
  // mean of the samples, widened to the left-aligned word
  assign avg_val = (acc_next << 6) >> s_q.avg_exp;

  always_comb begin
    s_d = s_q;
    s_d.req = 1'b0;
    s_d.rdata = 16'h0000;
    // register reads: data stand one cycle after the strobe
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADR_CTRL_MAIN: begin
          s_d.rdata[B_POWER_EN] = s_q.power_en;
          s_d.rdata[B_GO_BUSY] = s_q.go_busy;
          s_d.rdata[B_FREE_RUN] = s_q.free_run;
          s_d.rdata[B_SINGLE_END] = s_q.single_end;
          s_d.rdata[B_DONE_FLAG] = s_q.done_flag;
          s_d.rdata[B_CHAN_LSB +: CHAN_W] = s_q.chan;
          s_d.rdata[B_READY] = (s_q.st != ST_OFF) && (s_q.st != ST_SETTLE);
        end
        ADR_CTRL_SECOND: begin
          s_d.rdata[B_SCALE_LSB +: SCALE_W] = s_q.scale;
          s_d.rdata[B_AVG_LSB +: AVG_W] = s_q.avg_exp;
          s_d.rdata[B_SHIFT_EN] = s_q.shift_en;
          s_d.rdata[B_CM_LSB +: CM_W] = s_q.cm_adj;
        end
        ADR_CTRL_THIRD: begin
          s_d.rdata[B_SETTLE_LSB +: SETTLE_W] = s_q.settle;
          s_d.rdata[B_GAP_LSB +: GAP_W] = s_q.gap;
        end
        ADR_RESULT: s_d.rdata = s_q.result;
        ADR_LAST_RAW: s_d.rdata[RAW_W-1:0] = s_q.last_raw;
        default: s_d.rdata = 16'h0000;
      endcase
    end
    // configuration writes; software keeps these still while busy
    if (wr_main) begin
      s_d.power_en = reg_wdata_i[B_POWER_EN];
      s_d.free_run = reg_wdata_i[B_FREE_RUN];
      s_d.single_end = reg_wdata_i[B_SINGLE_END];
      s_d.chan = reg_wdata_i[B_CHAN_LSB +: CHAN_W];
    end
    if (reg_wr_i && (reg_addr_i == ADR_CTRL_SECOND)) begin
      s_d.scale = reg_wdata_i[B_SCALE_LSB +: SCALE_W];
      s_d.avg_exp = reg_wdata_i[B_AVG_LSB +: AVG_W];
      s_d.shift_en = reg_wdata_i[B_SHIFT_EN];
      s_d.cm_adj = reg_wdata_i[B_CM_LSB +: CM_W];
    end
    if (reg_wr_i && (reg_addr_i == ADR_CTRL_THIRD)) begin
      s_d.settle = reg_wdata_i[B_SETTLE_LSB +: SETTLE_W];
      s_d.gap = reg_wdata_i[B_GAP_LSB +: GAP_W];
    end
    // flag clear by writing one; a set in the same cycle wins below
    if (reg_wr_i && (reg_addr_i == ADR_FLAG_CLR) && reg_wdata_i[B_DONE_FLAG]) begin
      s_d.done_flag = 1'b0;
    end

    unique case (s_q.st)
      ST_OFF: begin
        s_d.go_busy = 1'b0;
        if (s_d.power_en) begin
          s_d.st = ST_SETTLE;
          s_d.settle_cnt = '0;
        end
      end
      ST_SETTLE: begin
        s_d.go_busy = 1'b0;
        if (s_q.settle_cnt >= (SETTLE_W + 2)'(SETTLE_UNIT) * {2'b00, s_q.settle}) begin
          s_d.st = ST_READY;
        end else begin
          s_d.settle_cnt = s_q.settle_cnt + 1'b1;
        end
      end
      ST_READY: begin
        // start only taken here, so a busy start is dropped
        if (wr_main && reg_wdata_i[B_GO_BUSY]) begin
          s_d.go_busy = 1'b1;
          s_d.st = ST_SAMPLE;
          s_d.smp_cnt = '0;
          s_d.acc = '0;
        end
      end
      ST_SAMPLE: begin
        s_d.req = 1'b1;
        s_d.st = ST_WAIT;
      end
      ST_WAIT: begin
        if (sample_done_i) begin
          s_d.last_raw = sample_data_i;
          s_d.acc = acc_next;
          if (s_q.smp_cnt == smp_total - 8'h01) begin
            s_d.result = avg_val[RES_W-1:0];
            s_d.done_flag = 1'b1;
            s_d.acc = '0;
            s_d.smp_cnt = '0;
            if (s_d.free_run) begin
              if (s_q.gap == '0) begin
                s_d.st = ST_SAMPLE;
              end else begin
                s_d.st = ST_ALIGN;
                s_d.gap_cnt = s_q.gap;
              end
            end else begin
              s_d.go_busy = 1'b0;
              s_d.st = ST_READY;
            end
          end else begin
            s_d.smp_cnt = s_q.smp_cnt + 8'h01;
            s_d.st = ST_SAMPLE;
          end
        end
      end
      ST_ALIGN: begin
        // wait for the slow tick edge; adds up to one step
        if (!s_d.free_run) begin
          s_d.go_busy = 1'b0;
          s_d.st = ST_READY;
        end else if (tick) begin
          s_d.st = ST_GAP;
        end
      end
      ST_GAP: begin
        if (!s_d.free_run) begin
          s_d.go_busy = 1'b0;
          s_d.st = ST_READY;
        end else if (tick) begin
          if (s_q.gap_cnt == GAP_W'(1)) begin
            s_d.st = ST_SAMPLE;
          end else begin
            s_d.gap_cnt = s_q.gap_cnt - 1'b1;
          end
        end
      end
      default: s_d.st = ST_OFF;
    endcase

    if (!s_d.power_en) begin
      s_d.st = ST_OFF;
      s_d.go_busy = 1'b0;
      s_d.req = 1'b0;
    end
  end

  // the whole machine runs on the converter clock
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.st <= ST_OFF;
      s_q.settle <= RST_CTRL_THIRD[B_SETTLE_LSB +: SETTLE_W];
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o = s_q.rdata;
  assign ldo_enable_o = (s_q.st != ST_OFF);
  assign conv_enable_o = (s_q.st != ST_OFF) && (s_q.st != ST_SETTLE);
  assign sample_req_o = s_q.req;
  assign chan_select_o = s_q.chan;
  assign single_ended_select_o = s_q.single_end;
  assign input_scale_select_o = s_q.scale;
  assign input_shift_enable_o = s_q.shift_en;
  assign common_mode_adjust_o = s_q.cm_adj;
  assign conv_done_flag_o = s_q.done_flag;
endmodule // adcseq_top
`default_nettype wire

// File: rtl/adcseq_pkg.sv
/*
 package for the converter sequencer: register offsets, field layout,
 reset values, timing constants and state codes.
 assumes a 10 mhz core clock and a 16-bit word register port.
*/
package adcseq_pkg;
  // register indices on the plain register port
  localparam logic [3:0] ADR_CTRL_MAIN = 4'h0;
  localparam logic [3:0] ADR_CTRL_SECOND = 4'h1;
  localparam logic [3:0] ADR_CTRL_THIRD = 4'h2;
  localparam logic [3:0] ADR_RESULT = 4'h3;
  localparam logic [3:0] ADR_FLAG_CLR = 4'h4;
  localparam logic [3:0] ADR_LAST_RAW = 4'h5;

  // main control field positions
  localparam int B_POWER_EN = 0;
  localparam int B_GO_BUSY = 1;
  localparam int B_FREE_RUN = 2;
  localparam int B_SINGLE_END = 3;
  localparam int B_DONE_FLAG = 4;
  localparam int B_CHAN_LSB = 8;
  localparam int CHAN_W = 3;
  localparam int B_READY = 12;

  // second control field positions
  localparam int B_SCALE_LSB = 0;
  localparam int SCALE_W = 2;
  localparam int B_AVG_LSB = 4;
  localparam int AVG_W = 3;
  localparam int B_SHIFT_EN = 8;
  localparam int B_CM_LSB = 9;
  localparam int CM_W = 2;

  // third control field positions
  localparam int B_SETTLE_LSB = 0;
  localparam int SETTLE_W = 8;
  localparam int B_GAP_LSB = 8;
  localparam int GAP_W = 8;

  // reset values
  localparam logic [15:0] RST_CTRL_MAIN = 16'h0000;
  localparam logic [15:0] RST_CTRL_SECOND = 16'h0000;
  localparam logic [15:0] RST_CTRL_THIRD = 16'h0040;

  // timing
  localparam int SETTLE_UNIT = 4;
  localparam int CLK_KHZ = 10_000;
  localparam int GAP_STEP_NS = 1_024_000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int GAP_STEP_CYC = GAP_STEP_NS / CLK_PERIOD_NS;
  localparam int GAP_CNT_W = 14;

  localparam int RAW_W = 10;
  localparam int RES_W = 16;
  localparam int ACC_W = 17;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_SETTLE = 3'b001,
    ST_READY = 3'b010,
    ST_SAMPLE = 3'b011,
    ST_WAIT = 3'b100,
    ST_ALIGN = 3'b101,
    ST_GAP = 3'b110
  } adcseq_state_e;
endpackage : adcseq_pkg

// File: rtl/adcseq_tick.sv
/*
 slow delay clock: a free-running divider giving a one-cycle tick
 every gap step. assumes one core clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module adcseq_tick #(
  parameter int STEP_CYC = adcseq_pkg::GAP_STEP_CYC
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // tick
  output logic tick_o
);
  import adcseq_pkg::*;

  typedef struct packed {
    logic [GAP_CNT_W-1:0] cnt;
    logic tick;
  } adcseq_tick_s;

  adcseq_tick_s s_q;
  adcseq_tick_s s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == GAP_CNT_W'(STEP_CYC - 1)) begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_o = s_q.tick;
endmodule // adcseq_tick
`default_nettype wire

// File: tb/adcseq_checker.sv
/* port assertions for the sequencer.
   assumes binding into adcseq_top, one clock domain. */
`timescale 1ns/10ps
`default_nettype none
module adcseq_checker (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  // analogue core
  input wire logic ldo_enable_o,
  input wire logic conv_enable_o,
  input wire logic sample_req_o,
  input wire logic [adcseq_pkg::CHAN_W-1:0] chan_select_o,
  input wire logic single_ended_select_o,
  input wire logic [adcseq_pkg::SCALE_W-1:0] input_scale_select_o,
  input wire logic sample_done_i,
  input wire logic conv_done_flag_o
);
  import adcseq_pkg::*;
  logic [15:0] wd_q;
  always_ff @(posedge core_clk_i) begin
    wd_q <= reg_wdata_i;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  ldo_first_a: assert property ($rose(conv_enable_o) |-> $past(ldo_enable_o))
    else $error("converter enabled without regulator");
  settle_start_a: assert property (reg_wr_i && reg_addr_i == ADR_CTRL_MAIN && reg_wdata_i[B_POWER_EN]
    && !ldo_enable_o |=> ldo_enable_o && !conv_enable_o) else $error("no settle phase");
  power_off_a: assert property (reg_wr_i && reg_addr_i == ADR_CTRL_MAIN && !reg_wdata_i[B_POWER_EN]
    |=> !ldo_enable_o && !conv_enable_o) else $error("power clear ignored");
  req_ready_a: assert property (sample_req_o |-> conv_enable_o ##1 !sample_req_o)
    else $error("bad sample request");
  flag_cause_a: assert property ($rose(conv_done_flag_o) |-> $past(sample_done_i))
    else $error("flag without sample");
  rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
    else $error("read data outside answer cycle");
  scale_copy_a: assert property (reg_wr_i && reg_addr_i == ADR_CTRL_SECOND
    |=> input_scale_select_o == wd_q[B_SCALE_LSB +: SCALE_W]) else $error("scale not taken");
  chan_copy_a: assert property (reg_wr_i && reg_addr_i == ADR_CTRL_MAIN |=>
    chan_select_o == wd_q[B_CHAN_LSB +: CHAN_W] && single_ended_select_o == wd_q[B_SINGLE_END])
    else $error("channel or mode not taken");
endmodule // adcseq_checker
`default_nettype wire

// File: tb/adcseq_core_model.sv
/* analogue core model: one done pulse per request after 1 to 4 cycles.
   assumes the sequencer clock; data is junk outside the done pulse. */
`timescale 1ns/10ps
`default_nettype none
module adcseq_core_model (
  // clock
  input wire logic core_clk_i,
  // sample handshake
  input wire logic sample_req_i,
  output logic sample_done_o,
  output logic [adcseq_pkg::RAW_W-1:0] sample_data_o
);
  initial begin
    sample_done_o = 1'b0;
    sample_data_o = '0;
    forever begin
      @(posedge core_clk_i);
      if (sample_req_i) begin
        repeat ($urandom_range(4, 1)) @(posedge core_clk_i);
        sample_done_o <= 1'b1;
        sample_data_o <= adcseq_pkg::RAW_W'($urandom);
        @(posedge core_clk_i);
        sample_done_o <= 1'b0;
        // stale data must not look valid
        sample_data_o <= ~sample_data_o;
      end
    end
  end
endmodule // adcseq_core_model
`default_nettype wire

// File: tb/adcseq_top_bench.sv
/* self-checking bench for adcseq_top with random settle, scale and samples.
   assumes adcseq_core_model as analogue core; binds adcseq_checker. */
`timescale 1ns/10ps
`default_nettype none
module adcseq_top_bench;
  import adcseq_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [15:0] reg_rdata_o, rv;
  logic ldo_enable_o, conv_enable_o, sample_req_o, sample_done_i, conv_done_flag_o;
  logic [CHAN_W-1:0] chan_select_o;
  logic [SCALE_W-1:0] input_scale_select_o;
  logic [CM_W-1:0] common_mode_adjust_o;
  logic single_ended_select_o, input_shift_enable_o;
  logic [15:0] d1, d2;
  logic [RAW_W-1:0] sample_data_i, last_raw;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n_req = 0;
  int sum, s, t, n0;
  adcseq_top u_adcseq_top (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .ldo_enable_o(ldo_enable_o), .conv_enable_o(conv_enable_o), .sample_req_o(sample_req_o),
    .chan_select_o(chan_select_o), .single_ended_select_o(single_ended_select_o),
    .input_scale_select_o(input_scale_select_o), .input_shift_enable_o(input_shift_enable_o),
    .common_mode_adjust_o(common_mode_adjust_o), .sample_done_i(sample_done_i), .sample_data_i(sample_data_i),
    .conv_done_flag_o(conv_done_flag_o));
  adcseq_core_model u_adcseq_core_model (.core_clk_i(core_clk_i), .sample_req_i(sample_req_o),
    .sample_done_o(sample_done_i), .sample_data_o(sample_data_i));
  initial forever #50 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    n_req = n_req + int'(sample_req_o);
    if (sample_done_i) begin
      sum = sum + int'(sample_data_i);
      last_raw = sample_data_i;
    end
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 rv = reg_rdata_o;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic poll_idle();
    int i;
    for (i = 0; i < 300; i++) begin
      rd(ADR_CTRL_MAIN);
      if (rv[B_GO_BUSY] === 1'b0) break;
    end
    chk(16'(i < 300), 16'h0001);
  endtask
  task automatic results();
    $display("mismatches %0d, compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    // the gap test needs up to two slow steps; the rest is short
    #(40_000 * CLK_PERIOD_NS);
    n_mismatch++;
    $display("Error at %0t: watchdog expired", $time);
    results();
  end
  initial begin
    void'($urandom(54));
    repeat (6) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(ADR_CTRL_THIRD);
    chk(rv, RST_CTRL_THIRD);
    rd(4'hF);
    chk(rv, 16'h0000);
    s = $urandom_range(4, 1);
    wr(ADR_CTRL_THIRD, 16'(s));
    wr(ADR_CTRL_MAIN, 16'h0001);
    // start during settle must be dropped
    wr(ADR_CTRL_MAIN, 16'h0003);
    #1 t = 2;
    while (!conv_enable_o && t < 100) begin
      #100 t++;
    end
    chk(16'(t >= 4 * s && t <= 4 * s + 3), 16'h0001);
    rd(ADR_CTRL_MAIN);
    chk(16'({rv[B_READY], rv[B_GO_BUSY]}), 16'h0002);
    for (int k = 0; k < 3; k++) begin
      d2 = 16'(k << B_AVG_LSB) | 16'($urandom_range(3, 0)) | 16'($urandom_range(7, 0) << B_SHIFT_EN);
      wr(ADR_CTRL_SECOND, d2);
      #1 chk(16'({common_mode_adjust_o, input_shift_enable_o, input_scale_select_o}),
        16'({d2[B_CM_LSB +: CM_W], d2[B_SHIFT_EN], d2[B_SCALE_LSB +: SCALE_W]}));
      rd(ADR_CTRL_SECOND);
      chk(rv, d2);
      d1 = 16'h0003 | 16'($urandom_range(7, 0) << B_CHAN_LSB) | 16'($urandom_range(1, 0) << B_SINGLE_END);
      sum = 0;
      n0 = n_req;
      wr(ADR_CTRL_MAIN, d1);
      #1 chk(16'({chan_select_o, single_ended_select_o}),
        16'({d1[B_CHAN_LSB +: CHAN_W], d1[B_SINGLE_END]}));
      rd(ADR_CTRL_MAIN);
      chk(16'(rv[B_GO_BUSY]), 16'h0001);
      wr(ADR_CTRL_MAIN, d1);
      poll_idle();
      chk(16'(n_req - n0), 16'(1 << k));
      chk(16'(rv[B_DONE_FLAG]), 16'h0001);
      chk(16'(conv_done_flag_o), 16'h0001);
      rd(ADR_RESULT);
      // averaged result keeps the fraction bits below the ten-bit lsb
      chk(rv, 16'((sum << 6) >> k));
      wr(ADR_FLAG_CLR, 16'h0010);
      #1 chk(16'(conv_done_flag_o), 16'h0000);
    end
    wr(ADR_CTRL_SECOND, 16'h0000);
    n0 = n_req;
    wr(ADR_CTRL_MAIN, 16'h0007);
    repeat (60) @(posedge core_clk_i);
    chk(16'(n_req - n0 >= 5), 16'h0001);
    wr(ADR_CTRL_MAIN, 16'h0001);
    poll_idle();
    rd(ADR_RESULT);
    chk(rv, {last_raw, 6'h00});
    rd(ADR_LAST_RAW);
    chk(rv, 16'(last_raw));
    n0 = n_req;
    repeat (30) @(posedge core_clk_i);
    chk(16'(n_req - n0), 16'h0000);
    wr(ADR_CTRL_THIRD, 16'(s) | 16'(1 << B_GAP_LSB));
    wr(ADR_CTRL_MAIN, 16'h0007);
    @(posedge sample_done_i);
    t = 0;
    while (sample_req_o !== 1'b1 && t < 3 * GAP_STEP_CYC) begin
      @(posedge core_clk_i);
      #1 t++;
    end
    // one gap step plus up to one step of alignment to the slow tick
    chk(16'(t > GAP_STEP_CYC && t <= 2 * GAP_STEP_CYC + 4), 16'h0001);
    wr(ADR_CTRL_MAIN, 16'h0001);
    poll_idle();
    wr(ADR_CTRL_MAIN, 16'h0000);
    #1 chk(16'({ldo_enable_o, conv_enable_o}), 16'h0000);
    results();
  end
endmodule // adcseq_top_bench
bind adcseq_top adcseq_checker u_adcseq_checker (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .ldo_enable_o(ldo_enable_o), .conv_enable_o(conv_enable_o),
  .sample_req_o(sample_req_o), .chan_select_o(chan_select_o), .single_ended_select_o(single_ended_select_o),
  .input_scale_select_o(input_scale_select_o), .sample_done_i(sample_done_i),
  .conv_done_flag_o(conv_done_flag_o));
`default_nettype wire
